// [testbench/cpu_event_model.sv]
// cpu-side event source: flash reads, exception sequences, sleep, bus release
// assumes the bench raises go for one cycle with kind already valid
`timescale 1ns/1ps
`default_nettype none
module cpu_event_model (
   input wire logic sys_clk,
   input wire logic go,
   input wire logic [2:0] kind,
   output logic flash_rd,
   output logic flash_rd_overlaid,
   output logic exc_seq,
   output logic exc_excluded,
   output logic sleep_exec,
   output logic bus_released
);
   // one-cycle events, qualifiers travel with their event so none is seen alone
   always @(posedge sys_clk) begin
      flash_rd <= go && (kind <= 3'h1);
      flash_rd_overlaid <= go && (kind == 3'h1);
      exc_seq <= go && (kind inside {3'h2, 3'h3});
      exc_excluded <= go && (kind == 3'h3);
      sleep_exec <= go && (kind == 3'h4);
      bus_released <= go && (kind == 3'h5);
   end
endmodule
`default_nettype wire

// [testbench/flash_block_select_overlay_ctrl_tb.sv]
// self-checking bench for the flash block-select and overlay control block
// assumes the package constants and a zero-wait apb slave as handed over
`timescale 1ns/1ps
`default_nettype none
module flash_block_select_overlay_ctrl_tb;
   localparam logic [11:0] A_MODE = flash_ctrl_pkg::MODE_CTRL_ADDR;
   localparam logic [11:0] A_LARGE = flash_ctrl_pkg::LARGE_SEL_ADDR;
   localparam logic [11:0] A_SMALL = flash_ctrl_pkg::SMALL_SEL_ADDR;
   localparam logic [11:0] A_OVL = flash_ctrl_pkg::OVERLAY_ADDR;
   logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic flash_mode_en, vpp_present, hw_standby, sw_standby;
   logic flash_rd, flash_rd_overlaid, exc_seq, exc_excluded, sleep_exec, bus_released;
   logic prog_mode, erase_mode, prog_supply_enable, prog_erase_allowed, flash_error_flag;
   logic [7:0] large_block_bits, small_block_bits, lb, sb;
   logic [23:0] ram_window_base;
   logic ev_go;
   logic [2:0] ev_kind;
   int n_fail, total_checks, cycles, a0;

   flash_block_select_overlay_ctrl flash_block_select_overlay_ctrl_i (.sys_clk, .rst_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .flash_mode_en, .vpp_present, .hw_standby,
      .sw_standby, .flash_rd, .flash_rd_overlaid, .exc_seq, .exc_excluded, .sleep_exec, .bus_released,
      .prog_mode, .erase_mode, .prog_supply_enable, .prog_erase_allowed, .large_block_bits,
      .small_block_bits, .flash_error_flag, .ram_window_base);

   cpu_event_model cpu_event_model_i (.sys_clk, .go(ev_go), .kind(ev_kind), .flash_rd, .flash_rd_overlaid,
      .exc_seq, .exc_excluded, .sleep_exec, .bus_released);

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // hang guard, generous against the roughly 600 cycles the sequence needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (n_fail == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until the rising edge that sees pready, answer taken there
   // no own wait limit: a slave that never answers is caught by the hang guard
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(rd, exp);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask

   task automatic stby(input logic hw);
      @(posedge sys_clk);
      hw_standby <= hw;
      sw_standby <= !hw;
      @(posedge sys_clk);
      hw_standby <= 1'b0;
      sw_standby <= 1'b0;
   endtask

   // event waits three edges after the model register: flag register plus two of margin
   task automatic fire(input logic [2:0] k);
      @(posedge sys_clk);
      ev_kind <= k;
      ev_go <= 1'b1;
      @(posedge sys_clk);
      ev_go <= 1'b0;
      cyc(3);
   endtask

   function automatic logic [31:0] ovl_rd(input logic fl, input logic [3:0] low);
      return {24'h0, fl, flash_ctrl_pkg::OVL_RSVD_ONES, low};
   endfunction

   function automatic logic [23:0] win(input logic [3:0] v);
      return v[3] ? flash_ctrl_pkg::RAM_OVL_BASE + {12'h0, v[2:0], 9'h0} : flash_ctrl_pkg::RAM_HOME_BASE;
   endfunction

   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, hw_standby, sw_standby, ev_go, ev_kind} = '0;
      flash_mode_en = 1'b1;
      vpp_present = 1'b1;
      void'($urandom(32'hc08c));
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      // reset state and an unmapped word
      rdchk(A_MODE, 32'h80);
      rdchk(A_LARGE, 32'h0);
      rdchk(A_SMALL, 32'h0);
      rdchk(A_OVL, 32'h70);
      cmp({8'h0, ram_window_base}, {8'h0, win(4'h0)});
      apb(1'b0, 12'h1f0, 32'h0);
      cmp({31'h0, err}, 32'h1);
      // flash-disabled modes lock the selects
      flash_mode_en <= 1'b0;
      wr(A_LARGE, 32'h5a);
      rdchk(A_LARGE, 32'hff);
      rdchk(A_SMALL, 32'hff);
      flash_mode_en <= 1'b1;
      rdchk(A_LARGE, 32'h0);
      // supply first, since selects clear while it is off
      wr(A_MODE, 32'h40);
      lb = 8'($urandom);
      sb = 8'($urandom);
      wr(A_LARGE, {24'h0, lb});
      wr(A_SMALL, {24'h0, sb});
      rdchk(A_LARGE, {24'h0, lb});
      rdchk(A_SMALL, {24'h0, sb});
      cmp({31'h0, prog_supply_enable}, 32'h1);
      cyc(25);
      cmp({31'h0, prog_erase_allowed}, 32'h0);
      cyc(25);
      cmp({31'h0, prog_erase_allowed}, 32'h1);
      cmp({16'h0, large_block_bits, small_block_bits}, {16'h0, lb, sb});
      // program and erase bits, one at a time
      wr(A_MODE, 32'h41);
      cyc(2);
      cmp({30'h0, prog_mode, erase_mode}, 32'h2);
      rdchk(A_MODE, 32'hc1);
      wr(A_MODE, 32'h42);
      cyc(2);
      cmp({30'h0, prog_mode, erase_mode}, 32'h1);
      wr(A_MODE, 32'h40);
      // overlay: top bits ignore writes, select protects every block
      wr(A_OVL, 32'hff);
      rdchk(A_OVL, ovl_rd(1'b0, 4'hf));
      cyc(3);
      cmp({31'h0, prog_erase_allowed}, 32'h0);
      cmp({16'h0, large_block_bits, small_block_bits}, 32'h0);
      a0 = $urandom_range(7);
      for (int i = 0; i < 8; i++) begin
         wr(A_OVL, {28'h0, 1'b1, 3'(a0 + i)});
         cyc(2);
         cmp({8'h0, ram_window_base}, {8'h0, win({1'b1, 3'(a0 + i)})});
      end
      wr(A_OVL, 32'h05);
      cyc(3);
      cmp({8'h0, ram_window_base}, {8'h0, win(4'h5)});
      cmp({31'h0, prog_erase_allowed}, 32'h1);
      // software standby keeps the overlay, hardware standby clears it
      wr(A_OVL, 32'h0b);
      stby(1'b0);
      rdchk(A_OVL, ovl_rd(1'b0, 4'hb));
      rdchk(A_LARGE, 32'h0);
      stby(1'b1);
      rdchk(A_OVL, 32'h70);
      // each cpu event during program or erase; pass 6 fires kind 0, a read, with no mode bit set
      for (int k = 0; k < 7; k++) begin
         e = (k == 0 || k == 2 || k == 4 || k == 5);
         wr(A_MODE, 32'h40);
         if (k < 6) begin
            wr(A_MODE, k[0] ? 32'h41 : 32'h42);
         end
         fire(k < 6 ? 3'(k) : 3'h0);
         cmp({31'h0, flash_error_flag}, {31'h0, e});
         wr(A_OVL, 32'h00);
         rdchk(A_OVL, ovl_rd(e, 4'h0));
         if (e) begin
            // let the supply settle so only the error flag can hold the gate shut
            cyc(50);
            cmp({31'h0, prog_erase_allowed}, 32'h0);
         end
         stby(1'b1);
         cyc(1);
         cmp({31'h0, flash_error_flag}, 32'h0);
      end
      // losing the 12 v supply or its enable clears the selects
      wr(A_MODE, 32'h40);
      wr(A_LARGE, 32'h3c);
      rdchk(A_LARGE, 32'h3c);
      vpp_present <= 1'b0;
      cyc(2);
      rdchk(A_LARGE, 32'h0);
      vpp_present <= 1'b1;
      wr(A_MODE, 32'h40);
      wr(A_SMALL, 32'ha5);
      rdchk(A_SMALL, 32'ha5);
      wr(A_MODE, 32'h00);
      rdchk(A_SMALL, 32'h0);
      // second reset in mid-run
      wr(A_OVL, 32'h0c);
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      rdchk(A_OVL, 32'h70);
      cmp({8'h0, ram_window_base}, {8'h0, win(4'h0)});
      end_sim();
   end
endmodule
`default_nettype wire

// [verilog/blk_sel_if.sv]
// carries one block-select register between the top and its holder
// assumes a single clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface blk_sel_if;
   logic wr;
   logic clr;
   logic [7:0] wdata;
   logic [7:0] bits;
   modport ctrl (output wr, output clr, output wdata, input bits);
   modport regs (input wr, input clr, input wdata, output bits);
endinterface
`default_nettype wire

// [verilog/block_select_reg.sv]
// one eight-bit block-select register with its clear conditions
// assumes the top has already qualified write and clear
`timescale 1ns/1ps
`default_nettype none
module block_select_reg (
   input wire logic sys_clk,
   input wire logic rst_n,
   blk_sel_if.regs port
);
   typedef struct packed {
      logic [7:0] bits;
   } blk_state_t;

   blk_state_t st_r;
   blk_state_t st_nxt;

   // clear beats a write in the same cycle, the supply is gone anyway
   always_comb begin
      st_nxt = st_r;
      if (port.clr) begin
         st_nxt.bits = flash_ctrl_pkg::BLK_SEL_RESET;
      end else if (port.wr) begin
         st_nxt.bits = port.wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign port.bits = st_r.bits;
endmodule
`default_nettype wire

// [verilog/flash_block_select_overlay_ctrl.sv]
// flash mode control, block-select and ram overlay control behind apb
// assumes mode, supply and cpu event inputs are synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module flash_block_select_overlay_ctrl (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic flash_mode_en,
   input wire logic vpp_present,
   input wire logic hw_standby,
   input wire logic sw_standby,
   input wire logic flash_rd,
   input wire logic flash_rd_overlaid,
   input wire logic exc_seq,
   input wire logic exc_excluded,
   input wire logic sleep_exec,
   input wire logic bus_released,
   output logic prog_mode,
   output logic erase_mode,
   output logic prog_supply_enable,
   output logic prog_erase_allowed,
   output logic [7:0] large_block_bits,
   output logic [7:0] small_block_bits,
   output logic flash_error_flag,
   output logic [23:0] ram_window_base
);
   typedef struct packed {
      logic [3:0] mode;
      logic supply_en;
      logic err;
      logic ovl_sel;
      logic [2:0] area;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic allow;
      logic [7:0] lb;
      logic [7:0] sb;
      logic [23:0] base;
   } ctrl_state_t;

   ctrl_state_t st_r;
   ctrl_state_t st_nxt;

   blk_sel_if large_if ();
   blk_sel_if small_if ();

   logic supply_ready;
   logic setup_ph;
   logic wr_take;
   logic busy;
   logic blk_clr;
   logic mapped;
   logic [7:0] rd_byte;
   logic [7:0] wbyte;

   // separate block-select holders, one per block area
   block_select_reg u_large (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .port(large_if.regs)
   );

   block_select_reg u_small (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .port(small_if.regs)
   );

   supply_settle_timer #(
      .CYCLES(flash_ctrl_pkg::SUPPLY_SETTLE_CYCLES)
   ) u_settle (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .enable(st_r.supply_en),
      .ready(supply_ready)
   );

   // apb phase decode; a write lands only at the access edge with pready
   assign setup_ph = psel && !penable;
   assign wr_take = psel && penable && st_r.pready && pwrite;
   assign wbyte = pwdata[7:0];
   assign busy = st_r.mode[flash_ctrl_pkg::MODE_PROG_BIT] || st_r.mode[flash_ctrl_pkg::MODE_ERASE_BIT];
   // selects survive only with supply present and enabled, outside standby
   assign blk_clr = hw_standby || sw_standby || !vpp_present || !st_r.supply_en;

   // block-select writes pass only when flash is enabled
   always_comb begin
      large_if.wr = wr_take && (paddr == flash_ctrl_pkg::LARGE_SEL_ADDR) && flash_mode_en;
      small_if.wr = wr_take && (paddr == flash_ctrl_pkg::SMALL_SEL_ADDR) && flash_mode_en;
      large_if.clr = blk_clr;
      small_if.clr = blk_clr;
      large_if.wdata = wbyte;
      small_if.wdata = wbyte;
   end

   // read mux; disabled modes show all ones on the mode and both select registers, not on overlay
   always_comb begin
      mapped = 1'b1;
      rd_byte = 8'h00;
      case (paddr)
         flash_ctrl_pkg::MODE_CTRL_ADDR: begin
            rd_byte = flash_mode_en ? {vpp_present, st_r.supply_en, 2'b00, st_r.mode}
                                    : flash_ctrl_pkg::DISABLED_READ;
         end
         flash_ctrl_pkg::LARGE_SEL_ADDR: begin
            rd_byte = flash_mode_en ? large_if.bits : flash_ctrl_pkg::DISABLED_READ;
         end
         flash_ctrl_pkg::SMALL_SEL_ADDR: begin
            rd_byte = flash_mode_en ? small_if.bits : flash_ctrl_pkg::DISABLED_READ;
         end
         flash_ctrl_pkg::OVERLAY_ADDR: begin
            rd_byte = {st_r.err, flash_ctrl_pkg::OVL_RSVD_ONES, st_r.ovl_sel, st_r.area};
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // next state of the whole block
   always_comb begin
      st_nxt = st_r;
      // no wait state: pready rises in the first access cycle
      st_nxt.pready = setup_ph;
      if (setup_ph) begin
         st_nxt.prdata = {24'h000000, rd_byte};
         st_nxt.pslverr = !mapped;
      end else begin
         st_nxt.pslverr = 1'b0;
      end
      // mode register: held cleared without supply, in standby, or flash off
      if (hw_standby || sw_standby || !vpp_present || !flash_mode_en) begin
         st_nxt.mode = 4'h0;
         st_nxt.supply_en = 1'b0;
      end else if (wr_take && paddr == flash_ctrl_pkg::MODE_CTRL_ADDR) begin
         st_nxt.mode = wbyte[3:0];
         st_nxt.supply_en = wbyte[flash_ctrl_pkg::MODE_SUPPLY_EN_BIT];
      end
      // overlay bits: software standby keeps them
      if (hw_standby) begin
         st_nxt.ovl_sel = 1'b0;
         st_nxt.area = 3'h0;
      end else if (wr_take && paddr == flash_ctrl_pkg::OVERLAY_ADDR) begin
         st_nxt.ovl_sel = wbyte[flash_ctrl_pkg::OVL_SEL_BIT];
         st_nxt.area = wbyte[2:0];
      end
      // error flag: hardware standby clears; software has no path to it
      if (hw_standby) begin
         st_nxt.err = 1'b0;
      end else if (busy && ((flash_rd && !flash_rd_overlaid)
                            || (exc_seq && !exc_excluded)
                            || sleep_exec
                            || bus_released)) begin
         st_nxt.err = 1'b1;
      end
      // protection gate for the flash array
      // enable is ANDed in too, since the timer's ready lags a dropped enable by one edge
      st_nxt.allow = !st_r.err && !st_r.ovl_sel && st_r.supply_en
                     && supply_ready && vpp_present;
      st_nxt.lb = st_nxt.allow ? large_if.bits : 8'h00;
      st_nxt.sb = st_nxt.allow ? small_if.bits : 8'h00;
      // ram window address; home base when overlay is off
      st_nxt.base = st_r.ovl_sel ? (flash_ctrl_pkg::RAM_OVL_BASE
                                    | {12'h000, st_r.area, 9'h000})
                                 : flash_ctrl_pkg::RAM_HOME_BASE;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.base <= flash_ctrl_pkg::RAM_HOME_BASE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign prog_mode = st_r.mode[flash_ctrl_pkg::MODE_PROG_BIT];
   assign erase_mode = st_r.mode[flash_ctrl_pkg::MODE_ERASE_BIT];
   assign prog_supply_enable = st_r.supply_en;
   assign prog_erase_allowed = st_r.allow;
   assign large_block_bits = st_r.lb;
   assign small_block_bits = st_r.sb;
   assign flash_error_flag = st_r.err;
   assign ram_window_base = st_r.base;

   // checks, all on sys_clk and masked while reset is low
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // cycles since supply enable rose, for the settle check
   logic [7:0] settle_cnt;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_cnt <= 8'h00;
      end else if (!st_r.supply_en) begin
         settle_cnt <= 8'h00;
      end else if (settle_cnt != 8'hff) begin
         settle_cnt <= settle_cnt + 8'h01;
      end
   end

   chk_prog_bit_write: assert property (
      wr_take && paddr == flash_ctrl_pkg::MODE_CTRL_ADDR && flash_mode_en && vpp_present
      && !hw_standby && !sw_standby
      |=> prog_mode == $past(pwdata[0]))
      else $error("program mode bit did not follow the write");

   chk_large_sel_write: assert property (
      large_if.wr && !blk_clr |=> large_if.bits == $past(pwdata[7:0]))
      else $error("large-block select did not take written value");

   chk_large_sel_clear: assert property (
      blk_clr |=> large_if.bits == 8'h00)
      else $error("large-block select not cleared");

   chk_small_sel_clear: assert property (
      blk_clr |=> small_if.bits == 8'h00 ##1 (small_block_bits == 8'h00))
      else $error("small-block select not cleared");

   chk_disabled_read_ones: assert property (
      setup_ph && !flash_mode_en
      && (paddr == flash_ctrl_pkg::LARGE_SEL_ADDR || paddr == flash_ctrl_pkg::SMALL_SEL_ADDR)
      |=> prdata[7:0] == 8'hff && pready)
      else $error("disabled mode block select did not read ones");

   chk_disabled_no_write: assert property (
      !flash_mode_en && !blk_clr |=> $stable(large_if.bits) && $stable(small_if.bits))
      else $error("block select changed in a flash-disabled mode");

   chk_error_blocks_prog: assert property (
      flash_error_flag |=> !prog_erase_allowed)
      else $error("programming allowed while error flag set");

   chk_error_sticky: assert property (
      flash_error_flag && !hw_standby |=> flash_error_flag)
      else $error("error flag cleared without hardware standby");

   chk_read_sets_error: assert property (
      busy && flash_rd && !flash_rd_overlaid && !hw_standby |=> flash_error_flag)
      else $error("flash read during programming did not set error");

   chk_overlay_read_quiet: assert property (
      !flash_error_flag && flash_rd && flash_rd_overlaid && !(exc_seq && !exc_excluded)
      && !sleep_exec && !bus_released |=> !flash_error_flag)
      else $error("overlaid ram read set the error flag");

   chk_exc_sets_error: assert property (
      busy && exc_seq && !exc_excluded && !hw_standby |=> flash_error_flag)
      else $error("exception during programming did not set error");

   chk_sleep_bus_error: assert property (
      busy && (sleep_exec || bus_released) && !hw_standby |=> flash_error_flag)
      else $error("sleep or bus release did not set error");

   chk_reserved_ones: assert property (
      setup_ph && paddr == flash_ctrl_pkg::OVERLAY_ADDR |=> prdata[6:4] == 3'h7)
      else $error("overlay reserved bits did not read ones");

   chk_overlay_protects: assert property (
      st_r.ovl_sel |=> !prog_erase_allowed && large_block_bits == 8'h00 && small_block_bits == 8'h00)
      else $error("overlay select did not protect the flash");

   chk_overlay_keep_sw: assert property (
      sw_standby && !hw_standby && !wr_take |=> $stable(st_r.ovl_sel) && $stable(st_r.area))
      else $error("overlay bits lost in software standby");

   chk_window_base: assert property (
      st_r.ovl_sel |=> ram_window_base == (24'h01f000 + {12'h000, $past(st_r.area), 9'h000}))
      else $error("overlay window base wrong");

   chk_supply_settle: assert property (
      prog_erase_allowed |-> settle_cnt >= 8'(flash_ctrl_pkg::SUPPLY_SETTLE_CYCLES))
      else $error("programming allowed before supply settled");

   chk_err_not_written: assert property (
      wr_take && paddr == flash_ctrl_pkg::OVERLAY_ADDR && !busy && !hw_standby
      |=> flash_error_flag == $past(flash_error_flag))
      else $error("overlay write changed the error flag");

   chk_small_sel_write: assert property (
      small_if.wr && !blk_clr |=> small_if.bits == $past(pwdata[7:0]))
      else $error("small-block select did not take written value");

   chk_vpp_loss_clear: assert property (
      !vpp_present |=> !prog_supply_enable && large_if.bits == 8'h00 && small_if.bits == 8'h00)
      else $error("selects or supply enable kept without programming supply");

   chk_outputs_gated: assert property (
      !prog_erase_allowed |-> large_block_bits == 8'h00 && small_block_bits == 8'h00)
      else $error("block selects reached the array while protected");

   chk_err_hw_clear: assert property (
      hw_standby |=> !flash_error_flag)
      else $error("error flag survived hardware standby");

   chk_overlay_hw_clear: assert property (
      hw_standby |=> !st_r.ovl_sel && st_r.area == 3'h0)
      else $error("overlay bits survived hardware standby");

   chk_overlay_write_takes: assert property (
      wr_take && paddr == flash_ctrl_pkg::OVERLAY_ADDR && !hw_standby
      |=> st_r.ovl_sel == $past(pwdata[3]) && st_r.area == $past(pwdata[2:0]))
      else $error("overlay write did not land in bits 3 to 0");

   cov_apb_write: cover property (setup_ph && pwrite ##1 penable && pready);
   cov_error_set: cover property (!flash_error_flag ##1 flash_error_flag);
   cov_prog_allowed: cover property (prog_mode && prog_erase_allowed);
   cov_overlay_on: cover property (st_r.ovl_sel && st_r.area == 3'h7);
endmodule
`default_nettype wire

// [verilog/flash_ctrl_pkg.sv]
// constants for the flash block-select and ram overlay control logic
// assumes a 10 MHz system clock and a 32-bit apb register bus
package flash_ctrl_pkg;
   // register indexes as printed; byte address is four times the index
   localparam logic [11:0] MODE_CTRL_IDX = 12'h040;
   localparam logic [11:0] LARGE_SEL_IDX = 12'h042;
   localparam logic [11:0] SMALL_SEL_IDX = 12'h043;
   localparam logic [11:0] OVERLAY_IDX = 12'h048;
   localparam logic [11:0] MODE_CTRL_ADDR = 12'h100;
   localparam logic [11:0] LARGE_SEL_ADDR = 12'h108;
   localparam logic [11:0] SMALL_SEL_ADDR = 12'h10c;
   localparam logic [11:0] OVERLAY_ADDR = 12'h120;

   // mode control fields
   localparam int MODE_PROG_BIT = 0;
   localparam int MODE_ERASE_BIT = 1;
   localparam int MODE_SUPPLY_EN_BIT = 6;
   localparam int MODE_VPP_BIT = 7;
   localparam logic [7:0] MODE_RESET = 8'h00;

   // block select fields
   localparam logic [7:0] BLK_SEL_RESET = 8'h00;
   localparam logic [7:0] DISABLED_READ = 8'hff;

   // overlay control fields
   localparam int OVL_ERR_BIT = 7;
   localparam int OVL_SEL_BIT = 3;
   localparam logic [2:0] OVL_RSVD_ONES = 3'h7;
   localparam logic [7:0] OVL_RESET = 8'h70;
   localparam logic [23:0] RAM_HOME_BASE = 24'hfff000;
   localparam logic [23:0] RAM_OVL_BASE = 24'h01f000;
   localparam int OVL_AREA_SHIFT = 9;

   // supply settling time
   localparam int CLK_PERIOD_NS = 100;
   localparam int SUPPLY_SETTLE_NS = 5000;
   localparam int SUPPLY_SETTLE_CYCLES = (SUPPLY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// [verilog/supply_settle_timer.sv]
// counts the settling time after the programming supply is enabled
// assumes enable is a level held by the top's mode register
`timescale 1ns/1ps
`default_nettype none
module supply_settle_timer #(
   parameter int CYCLES = flash_ctrl_pkg::SUPPLY_SETTLE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic enable,
   output logic ready
);
   typedef struct packed {
      logic [7:0] cnt;
      logic ready;
   } tmr_state_t;

   localparam logic [7:0] LAST = 8'(CYCLES - 1);

   tmr_state_t st_r;
   tmr_state_t st_nxt;

   // any drop of enable restarts the wait from zero
   always_comb begin
      st_nxt = st_r;
      if (!enable) begin
         st_nxt.cnt = 8'h00;
         st_nxt.ready = 1'b0;
      end else if (st_r.cnt != LAST) begin
         st_nxt.cnt = st_r.cnt + 8'h01;
      end else begin
         st_nxt.ready = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ready = st_r.ready;
endmodule
`default_nettype wire
